// [rtl/bcxs_regs.svh]
/*
  constants of the bus crossbar switch: port counts, widths, address map, priority ranks.
  assumes it is included by bare name wherever these values are needed.
*/
`ifndef BCXS_REGS_SVH
`define BCXS_REGS_SVH

// port counts and path widths
`define BCXS_NM        4
`define BCXS_NS        3
`define BCXS_AW        32
`define BCXS_DW        32
`define BCXS_IDW       2
`define BCXS_RKW       2

// master port indices
`define BCXS_M_IFETCH  2'h0
`define BCXS_M_LSU     2'h1
`define BCXS_M_DMA     2'h2
`define BCXS_M_NET     2'h3

// slave port indices
`define BCXS_S_FLASH   2'h0
`define BCXS_S_SRAM    2'h1
`define BCXS_S_BRIDGE  2'h2

// address decode on the top nibble
`define BCXS_MAP_MSB    31
`define BCXS_MAP_LSB    28
`define BCXS_MAP_FLASH  4'h0
`define BCXS_MAP_SRAM   4'h4
`define BCXS_MAP_BRIDGE 4'hC

// fixed ranks per master, higher wins; elevated rank beats every fixed one
`define BCXS_RANK_M0   2'h2
`define BCXS_RANK_M1   2'h1
`define BCXS_RANK_M2   2'h1
`define BCXS_RANK_M3   2'h0
`define BCXS_RANK_ELEV 2'h3

`endif

// [rtl/bcxs_pkg.sv]
/*
  types of the bus crossbar switch: request and answer bundles, slave port states.
  assumes bcxs_regs.svh sits on the include path.
*/
`include "bcxs_regs.svh"

package bcxs_pkg;

  // request from a master port, held until done
  typedef struct packed {
    logic                 valid;
    logic [`BCXS_AW-1:0]  addr;
    logic                 we;
    logic [`BCXS_DW-1:0]  wdata;
    logic                 lock;
    logic                 elev;
  } bcxs_mreq_s;

  // answer to a master port
  typedef struct packed {
    logic                 done;
    logic                 err;
    logic [`BCXS_DW-1:0]  rdata;
    logic                 stall;
  } bcxs_mrsp_s;

  // request presented to a slave port
  typedef struct packed {
    logic                  valid;
    logic [`BCXS_AW-1:0]   addr;
    logic                  we;
    logic [`BCXS_DW-1:0]   wdata;
    logic [`BCXS_IDW-1:0]  mid;
  } bcxs_sreq_s;

  // answer from a slave port
  typedef struct packed {
    logic                 ready;
    logic [`BCXS_DW-1:0]  rdata;
  } bcxs_srsp_s;

  typedef enum logic {SL_IDLE, SL_BUSY} bcxs_slv_e;

  typedef logic [`BCXS_IDW-1:0] bcxs_id_t;
  typedef logic [`BCXS_RKW-1:0] bcxs_rank_t;

endpackage

// [rtl/bcxs_arb.sv]
/*
  one slave port arbiter: highest rank wins, ties go round-robin after the last grant.
  assumes requests and ranks are stable for the cycle; purely combinational.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bcxs_regs.svh"

module bcxs_arb #(
  parameter int NM = `BCXS_NM
) (
  input  wire logic [NM-1:0]           i_req,      // eligible requesters
  input  wire bcxs_pkg::bcxs_rank_t    i_rank [NM], // effective rank per master
  input  wire bcxs_pkg::bcxs_id_t      i_last,     // last master granted
  output logic                         o_vld,      // some master granted
  output bcxs_pkg::bcxs_id_t           o_id        // granted master
);

  // best rank, then first tie at or after last plus one
  always_comb begin
    bcxs_pkg::bcxs_rank_t best;
    bcxs_pkg::bcxs_id_t   idx;
    best  = '0;
    o_vld = 1'b0;
    o_id  = '0;
    idx   = '0;
    for (int m = 0; m < NM; m++) begin
      if (i_req[m] && (!o_vld || i_rank[m] > best)) begin
        best  = i_rank[m];
        o_vld = 1'b1;
      end
    end
    for (int k = NM; k >= 1; k--) begin
      idx = bcxs_pkg::bcxs_id_t'((32'(i_last) + k) % NM);
      if (i_req[idx] && i_rank[idx] == best) begin
        o_id = idx;
      end
    end
  end

endmodule

`default_nettype wire

// [rtl/bcxs_crossbar.sv]
/*
  bus crossbar switch: four master ports to three slave ports, per-slave arbitration.
  assumes masters hold a request until done and drop or change it after the done cycle;
  slaves hold ready low until they answer a registered request.
*/
// Notes on behaviour
// - four masters, three slaves, parallel paths
// - 32-bit address and data everywhere
// - two in flight, one a flash fetch
// - contention for one slave goes to higher priority; between slaves the lower slave index wins
// - losers stall until winner finishes
// - equal priority served round-robin from last
// - fixed rank per master port
// - temporary elevation above fixed rank
`timescale 1ns/1ps
`default_nettype none
`include "bcxs_regs.svh"

module bcxs_crossbar #(
  parameter int                   NM     = `BCXS_NM,
  parameter int                   NS     = `BCXS_NS,
  parameter bcxs_pkg::bcxs_rank_t RANK0  = `BCXS_RANK_M0,
  parameter bcxs_pkg::bcxs_rank_t RANK1  = `BCXS_RANK_M1,
  parameter bcxs_pkg::bcxs_rank_t RANK2  = `BCXS_RANK_M2,
  parameter bcxs_pkg::bcxs_rank_t RANK3  = `BCXS_RANK_M3
) (
  input  wire logic                 i_core_clk,   // system clock, 20 MHz
  input  wire logic                 i_rst,        // async reset, active high
  input  wire bcxs_pkg::bcxs_mreq_s i_mreq [NM],  // master requests
  output bcxs_pkg::bcxs_mrsp_s      o_mrsp [NM],  // master answers
  output bcxs_pkg::bcxs_sreq_s      o_sreq [NS],  // slave requests
  input  wire bcxs_pkg::bcxs_srsp_s i_srsp [NS]   // slave answers
);

  // decode an address to a slave index, hit flag in the top bit
  function automatic logic [2:0] dec(input logic [`BCXS_AW-1:0] a);
    logic [3:0] n;
    n = a[`BCXS_MAP_MSB:`BCXS_MAP_LSB];
    unique case (n)
      `BCXS_MAP_FLASH:  dec = {1'b1, `BCXS_S_FLASH};
      `BCXS_MAP_SRAM:   dec = {1'b1, `BCXS_S_SRAM};
      `BCXS_MAP_BRIDGE: dec = {1'b1, `BCXS_S_BRIDGE};
      default:          dec = 3'h0;
    endcase
  endfunction

  // slave port state
  bcxs_pkg::bcxs_slv_e  sl_st     [NS];
  bcxs_pkg::bcxs_slv_e  next_sl_st[NS];
  logic [NS-1:0]        owned,    next_owned;
  bcxs_pkg::bcxs_id_t   owner     [NS];
  bcxs_pkg::bcxs_id_t   next_owner[NS];
  bcxs_pkg::bcxs_id_t   last      [NS];
  bcxs_pkg::bcxs_id_t   next_last [NS];
  logic [NS-1:0]        sl_fetch, next_sl_fetch;
  bcxs_pkg::bcxs_sreq_s next_sreq [NS];

  // master port state
  logic [NM-1:0]        m_act,    next_m_act;
  bcxs_pkg::bcxs_mrsp_s next_mrsp [NM];

  // arbiter hookup
  bcxs_pkg::bcxs_rank_t rank [NM];
  logic [NM-1:0]        cand [NS];
  logic [NS-1:0]        g_vld;
  bcxs_pkg::bcxs_id_t   g_id [NS];
  logic [2:0]           mdec [NM];

  localparam bcxs_pkg::bcxs_rank_t FIX [4] = '{RANK0, RANK1, RANK2, RANK3};

  // effective rank and decode per master
  always_comb begin
    for (int m = 0; m < NM; m++) begin
      rank[m] = i_mreq[m].elev ? `BCXS_RANK_ELEV : FIX[m];
      mdec[m] = dec(i_mreq[m].addr);
    end
  end

  // candidates per slave: waiting, mapped here, owner only if held
  always_comb begin
    for (int s = 0; s < NS; s++) begin
      for (int m = 0; m < NM; m++) begin
        cand[s][m] = i_mreq[m].valid && mdec[m][2] && (32'(mdec[m][1:0]) == s)
                     && !m_act[m] && !o_mrsp[m].done
                     && (!owned[s] || 32'(owner[s]) == m);
      end
    end
  end

  genvar gs;
  generate
    for (gs = 0; gs < NS; gs++) begin : g_arb
      bcxs_arb #(
        .NM (NM)
      ) u_arb (
        .i_req  (cand[gs]),
        .i_rank (rank),
        .i_last (last[gs]),
        .o_vld  (g_vld[gs]),
        .o_id   (g_id[gs])
      );
    end
  endgenerate

  // next state of slaves and masters
  always_comb begin
    logic nonfetch;
    logic is_fetch;
    nonfetch = 1'b0;
    is_fetch = 1'b0;
    next_m_act = m_act;
    for (int m = 0; m < NM; m++) begin
      next_mrsp[m] = '0;
      next_mrsp[m].rdata = o_mrsp[m].rdata;
    end
    for (int s = 0; s < NS; s++) begin
      if (sl_st[s] == bcxs_pkg::SL_BUSY && !sl_fetch[s]) begin
        nonfetch = 1'b1;
      end
    end
    for (int s = 0; s < NS; s++) begin
      next_sl_st[s]    = sl_st[s];
      next_owned[s]    = owned[s];
      next_owner[s]    = owner[s];
      next_last[s]     = last[s];
      next_sl_fetch[s] = sl_fetch[s];
      next_sreq[s]     = o_sreq[s];
      unique case (sl_st[s])
        bcxs_pkg::SL_BUSY: begin
          if (i_srsp[s].ready) begin
            next_sl_st[s]         = bcxs_pkg::SL_IDLE;
            next_sreq[s].valid    = 1'b0;
            next_m_act[owner[s]]  = 1'b0;
            next_mrsp[owner[s]].done  = 1'b1;
            next_mrsp[owner[s]].rdata = i_srsp[s].rdata;
            next_owned[s] = i_mreq[owner[s]].lock;
          end
        end
        bcxs_pkg::SL_IDLE: begin
          if (owned[s] && !i_mreq[owner[s]].lock && !i_mreq[owner[s]].valid) begin
            next_owned[s] = 1'b0;
          end
          is_fetch = (g_id[s] == `BCXS_M_IFETCH) && (32'(`BCXS_S_FLASH) == s);
          if (g_vld[s] && (is_fetch || !nonfetch)) begin
            if (!is_fetch) begin
              nonfetch = 1'b1;
            end
            next_sl_st[s]     = bcxs_pkg::SL_BUSY;
            next_owned[s]     = 1'b1;
            next_owner[s]     = g_id[s];
            next_last[s]      = g_id[s];
            next_sl_fetch[s]  = is_fetch;
            next_m_act[g_id[s]] = 1'b1;
            next_sreq[s].valid = 1'b1;
            next_sreq[s].addr  = i_mreq[g_id[s]].addr;
            next_sreq[s].we    = i_mreq[g_id[s]].we;
            next_sreq[s].wdata = i_mreq[g_id[s]].wdata;
            next_sreq[s].mid   = g_id[s];
          end
        end
      endcase
    end
    // unmapped requests end at once with error; others stall while unserved
    for (int m = 0; m < NM; m++) begin
      if (i_mreq[m].valid && !mdec[m][2] && !m_act[m] && !o_mrsp[m].done) begin
        next_mrsp[m].done = 1'b1;
        next_mrsp[m].err  = 1'b1;
      end
      next_mrsp[m].stall = i_mreq[m].valid && !next_m_act[m] && !next_mrsp[m].done
                           && !o_mrsp[m].done;
    end
  end

  // register all state and outputs
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int s = 0; s < NS; s++) begin
        sl_st[s]  <= bcxs_pkg::SL_IDLE;
        owner[s]  <= '0;
        last[s]   <= '0;
        o_sreq[s] <= '0;
      end
      owned    <= '0;
      sl_fetch <= '0;
      m_act    <= '0;
      for (int m = 0; m < NM; m++) begin
        o_mrsp[m] <= '0;
      end
    end else begin
      for (int s = 0; s < NS; s++) begin
        sl_st[s]  <= next_sl_st[s];
        owner[s]  <= next_owner[s];
        last[s]   <= next_last[s];
        o_sreq[s] <= next_sreq[s];
      end
      owned    <= next_owned;
      sl_fetch <= next_sl_fetch;
      m_act    <= next_m_act;
      for (int m = 0; m < NM; m++) begin
        o_mrsp[m] <= next_mrsp[m];
      end
    end
  end

endmodule

`default_nettype wire

// [bench/bcxs_checker.sv]
/* checker of the bus crossbar switch, port relations only.
   assumes it is bound onto bcxs_crossbar; one clock, async high reset. */
`timescale 1ns/1ps
`default_nettype none
module bcxs_checker #(
  parameter int NM = 4,
  parameter int NS = 3
) (
  input  wire logic                 i_core_clk, // clock
  input  wire logic                 i_rst,      // reset
  input  wire bcxs_pkg::bcxs_mreq_s i_mreq [NM], // master requests
  input  wire bcxs_pkg::bcxs_mrsp_s o_mrsp [NM], // master answers
  input  wire bcxs_pkg::bcxs_sreq_s o_sreq [NS], // slave requests
  input  wire bcxs_pkg::bcxs_srsp_s i_srsp [NS]  // slave answers
);
  logic pend_hi;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // higher ranked masters waiting on sram
  always_comb begin
    pend_hi = 1'b0;
    for (int m = 0; m < 3; m++) begin
      pend_hi = pend_hi | (i_mreq[m].valid && i_mreq[m].addr[31:28] == 4'h4 && !o_mrsp[m].done);
    end
  end
  // sram transfer of master 1: slave end, then master end
  sequence s_sram_end; o_sreq[1].valid && i_srsp[1].ready && o_sreq[1].mid == 2'h1; endsequence
  sequence s_m1_done; o_mrsp[1].done && o_mrsp[1].rdata == $past(i_srsp[1].rdata); endsequence
  property p_reset_idle; $fell(i_rst) |-> !(o_sreq[0].valid | o_sreq[1].valid | o_sreq[2].valid); endproperty
  property p_inflight; !(o_sreq[1].valid && o_sreq[2].valid) && !(o_sreq[0].valid
    && o_sreq[0].mid != 2'h0 && (o_sreq[1].valid || o_sreq[2].valid)); endproperty
  property p_hold; o_sreq[1].valid && !i_srsp[1].ready |=> o_sreq[1].valid
    && $stable(o_sreq[1].addr) && $stable(o_sreq[1].mid); endproperty
  property p_drop; o_sreq[1].valid && i_srsp[1].ready |=> !o_sreq[1].valid; endproperty
  property p_stall; i_mreq[3].valid && i_mreq[3].addr[31:28] == 4'h4 && !o_mrsp[3].done
    && o_sreq[1].valid && o_sreq[1].mid != 2'h3 |=> o_mrsp[3].stall; endproperty
  property p_done_data; s_sram_end |=> s_m1_done; endproperty
  property p_net_last; $rose(o_sreq[1].valid) && o_sreq[1].mid == 2'h3 && !$past(i_mreq[3].elev)
    && !$past(i_mreq[3].lock) |-> !$past(pend_hi); endproperty
  property p_unmapped; $rose(i_mreq[3].valid) && i_mreq[3].addr[31:28] == 4'h8
    |=> o_mrsp[3].done && o_mrsp[3].err; endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("slave request right after reset");
  a_inflight: assert property (p_inflight) else $error("too many transfers in flight");
  a_hold: assert property (p_hold) else $error("slave request changed while waiting");
  a_drop: assert property (p_drop) else $error("slave request kept after ready");
  a_stall: assert property (p_stall) else $error("losing master not stalled");
  a_done_data: assert property (p_done_data) else $error("read data not passed to master");
  a_net_last: assert property (p_net_last) else $error("lowest rank beat a higher one");
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not answered");
endmodule
bind bcxs_crossbar bcxs_checker #(.NM(NM), .NS(NS)) u_chk (.i_core_clk(i_core_clk),
  .i_rst(i_rst), .i_mreq(i_mreq), .o_mrsp(o_mrsp), .o_sreq(o_sreq), .i_srsp(i_srsp));
`default_nettype wire

// [bench/bcxs_slave_model.sv]
/* slave memory model: answers after a set number of wait cycles.
   assumes the wait count changes only while no request is open. */
`timescale 1ns/1ps
`default_nettype none
module bcxs_slave_model (
  input  wire logic                 i_core_clk, // clock
  input  wire logic                 i_rst,      // reset
  input  wire logic [1:0]           i_wait,     // wait cycles
  input  wire bcxs_pkg::bcxs_sreq_s i_sreq,     // request
  output bcxs_pkg::bcxs_srsp_s      o_srsp      // answer
);
  logic [1:0]  cnt;
  logic [31:0] tick;
  // wait counter and churn for idle data
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt <= 2'h0;
      tick <= 32'h0;
    end else begin
      cnt <= (i_sreq.valid && !o_srsp.ready) ? cnt + 2'h1 : 2'h0;
      tick <= tick + 32'h1;
    end
  end
  assign o_srsp.ready = i_sreq.valid && cnt == i_wait;
  assign o_srsp.rdata = o_srsp.ready ? i_sreq.addr ^ 32'h5A5A_0000 : ~tick;
endmodule
`default_nettype wire

// [bench/bcxs_crossbar_test.sv]
/* self-checking bench of the bus crossbar switch.
   assumes bcxs_pkg and the slave model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module bcxs_crossbar_test;
  logic                 i_core_clk;
  logic                 i_rst;
  bcxs_pkg::bcxs_mreq_s i_mreq [4];
  wire bcxs_pkg::bcxs_mrsp_s o_mrsp [4];
  wire bcxs_pkg::bcxs_sreq_s o_sreq [3];
  wire bcxs_pkg::bcxs_srsp_s i_srsp [3];
  logic [1:0]           wt [3];
  logic [32:0]          exp_q [4][$];
  logic [1:0]           gq [$];
  logic [15:0]          lfsr = 16'h46A1;
  logic                 sv_q = 1'b0;
  logic                 both = 1'b0;
  int                   mismatches = 0;
  int                   cmp_count = 0;
  bcxs_crossbar dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_mreq(i_mreq), .o_mrsp(o_mrsp),
    .o_sreq(o_sreq), .i_srsp(i_srsp));
  for (genvar s = 0; s < 3; s++) begin : g_slv
    bcxs_slave_model u_slv (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_wait(wt[s]),
      .i_sreq(o_sreq[s]), .o_srsp(i_srsp[s]));
  end
  always #25 i_core_clk = ~i_core_clk;
  task automatic check(string nm, logic [32:0] e, logic [32:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [31:0] ad(logic [3:0] nib);
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return {nib, 12'h000, lfsr};
  endfunction
  // one transfer: note expectation, hold request until done
  // each master drives its own port
  task automatic xfer(int m, logic [31:0] a, logic el);
    int n;
    n = 0;
    exp_q[m].push_back(a[31:28] == 4'h8 ? {1'b1, 32'h0} : {1'b0, a ^ 32'h5A5A_0000});
    @(posedge i_core_clk);
    i_mreq[m] <= '{valid: 1'b1, addr: a, we: lfsr[0], wdata: {lfsr, lfsr}, lock: 1'b0, elev: el};
    do begin
      @(posedge i_core_clk);
      n++;
    end while (o_mrsp[m].done !== 1'b1 && n < 200);
    if (o_mrsp[m].done !== 1'b1) check("done in time", 33'h1, 33'h0);
    i_mreq[m].valid <= 1'b0;
  endtask
  task report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // monitor: pop oldest note per done, and per sram grant
  always @(posedge i_core_clk) begin
    logic [32:0] e;
    if (!i_rst) begin
      for (int m = 0; m < 4; m++) begin
        if (o_mrsp[m].done === 1'b1) begin
          if (exp_q[m].size() == 0) begin
            check("unexpected done", 33'h0, 33'h1);
          end else begin
            e = exp_q[m].pop_front();
            check("answer", e, {o_mrsp[m].err, e[32] ? 32'h0 : o_mrsp[m].rdata});
          end
        end
      end
      if (o_sreq[1].valid === 1'b1 && !sv_q) begin
        if (gq.size() == 0) check("unexpected sram grant", 33'h0, 33'h1);
        else check("sram grant", gq.pop_front(), o_sreq[1].mid);
      end
      if (o_sreq[0].valid === 1'b1 && o_sreq[1].valid === 1'b1) both <= 1'b1;
      sv_q <= o_sreq[1].valid;
    end
  end
  initial begin
    repeat (4000) @(posedge i_core_clk);
    mismatches++;
    report_and_stop();
  end
  initial begin
    i_core_clk = 1'b0;
    i_rst = 1'b1;
    i_mreq = '{default: '0};
    wt = '{default: 2'h0};
    repeat (4) @(posedge i_core_clk);
    i_rst <= 1'b0;
    @(posedge i_core_clk);
    #1 check("idle after reset", 33'h0, {o_sreq[0].valid, o_sreq[1].valid, o_sreq[2].valid});
    for (int r = 0; r < 2; r++) begin
      wt <= '{lfsr[1:0], lfsr[3:2], lfsr[5:4]};
      gq = '{2'h1};
      fork xfer(0, ad(4'h0), 1'b0); xfer(1, ad(4'h4), 1'b0); xfer(3, ad(4'hC), 1'b0); join
      check("parallel paths", 33'h1, {32'h0, both});
      gq = '{2'h2, 2'h1};
      fork xfer(1, ad(4'h4), 1'b0); xfer(2, ad(4'h4), 1'b0); join
      gq = '{2'h0, 2'h1, 2'h2, 2'h3};
      fork xfer(0, ad(4'h4), 1'b0); xfer(1, ad(4'h4), 1'b0); xfer(2, ad(4'h4), 1'b0);
        xfer(3, ad(4'h4), 1'b0); join
      gq = '{2'h3, 2'h0, 2'h1, 2'h3};
      fork xfer(3, ad(4'h4), 1'b1); xfer(0, ad(4'h4), 1'b0); join
      fork xfer(3, ad(4'h4), 1'b0); xfer(1, ad(4'h4), 1'b0); join
      gq = '{2'h1};
      fork xfer(1, ad(4'h4), 1'b0); xfer(2, ad(4'h0), 1'b0); xfer(3, ad(4'h8), 1'b0); join
      $display("round %0d done", r);
    end
    repeat (3) @(posedge i_core_clk);
    check("notes left", 33'h0, {31'h0, gq.size() != 0,
      (exp_q[0].size() + exp_q[1].size() + exp_q[2].size() + exp_q[3].size()) != 0});
    report_and_stop();
  end
endmodule
`default_nettype wire
